// [rtl/dss_pkg.sv]
/*
  Shared constants of the drive safe stop sequencer: register map, field
  positions, reset values, timing counts and the sequencer state codes.
  Assumes a 250 MHz system clock and an APB master with 32-bit data.
*/
// Operation
// - Selecting safe_torque_off by fail-safe input or fieldbus removes motor torque.
// - safe_brake_control is active only with brake configured, it enabled and torque off.
// - safe_stop_one with brake ramps down, closes the brake at standstill, then goes torque off.
// - safe_torque_off selected while rotating closes the brake at once, whatever the speed; in the coast state brake_close stays low.
// - No restart is allowed while safe_stop_one stays selected.
// - Unmonitored safe_stop_one ramps down and enters torque off once the delay ends.
// - Ramp-monitored safe_stop_one checks falling speed and goes torque off at standstill.
// - Acceleration-monitored safe_stop_one supervises braking; a stopped motor goes off at once.
// - The status word shows each fail-safe input level as one bit, 0 low and 1 high.
// - A direction deviation with ramp reaction brakes on the quick stop ramp, then coasts.
// - The coast reaction removes torque and flags the torque-off state active.
package dss_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] DSS_OFS_CONFIG   = 8'h00;
  localparam logic [7:0] DSS_OFS_DELAY    = 8'h04;
  localparam logic [7:0] DSS_OFS_STATE    = 8'h08;
  localparam logic [7:0] DSS_OFS_FSI      = 8'h0C;
  localparam logic [7:0] DSS_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] DSS_OFS_IRQ_CLR  = 8'h14;
  localparam logic [7:0] DSS_OFS_IRQ_EN   = 8'h18;

  // ---------------------------------------------------------------
  // config fields
  // ---------------------------------------------------------------
  localparam int DSS_CFG_BRAKE  = 0;
  localparam int DSS_CFG_SBC_EN = 1;
  localparam int DSS_CFG_MODE   = 2;  // two bits: 3:2
  localparam int DSS_CFG_SDI_RR = 4;
  localparam int DSS_CFG_W      = 5;
  localparam logic [4:0] DSS_CFG_RST = 5'h00;

  // stop mode encoding
  localparam logic [1:0] DSS_MODE_NONE  = 2'h0;
  localparam logic [1:0] DSS_MODE_RAMP  = 2'h1;
  localparam logic [1:0] DSS_MODE_ACCEL = 2'h2;

  // interrupt bits
  localparam int DSS_EV_STO   = 0;
  localparam int DSS_EV_SS1   = 1;
  localparam int DSS_EV_SDI   = 2;
  localparam int DSS_EV_MON   = 3;
  localparam int DSS_EV_COAST = 4;
  localparam int DSS_EV_W     = 5;

  // ---------------------------------------------------------------
  // timing: delay counts in microsecond ticks
  // ---------------------------------------------------------------
  localparam int DSS_CLK_PERIOD_PS = 4000;
  localparam int DSS_TICK_NS       = 1000;
  localparam int DSS_TICK_CYC      = (DSS_TICK_NS * 1000) / DSS_CLK_PERIOD_PS;
  localparam logic [31:0] DSS_DELAY_RST = 32'h0000_03E8;

  // ---------------------------------------------------------------
  // sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    DSS_ST_RUN   = 5'h01,
    DSS_ST_SS1   = 5'h02,
    DSS_ST_STO   = 5'h04,
    DSS_ST_SDIR  = 5'h08,
    DSS_ST_COAST = 5'h10
  } dss_state_t;
endpackage

// [rtl/dss_delay_timer.sv]
/*
  Stop delay timer: counts microsecond ticks while running and flags
  expiry once the programmed limit is reached.
  Assumes tick is a one-cycle pulse in the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_delay_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  // status
  output logic              expired
);
  import dss_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } dss_tmr_t;

  dss_tmr_t t_reg;
  dss_tmr_t t_next;

  // ---------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------
  // clears the moment run drops so a reselection restarts from zero
  always_comb begin
    t_next = t_reg;
    if (!run) begin
      t_next.cnt  = '0;
      t_next.done = 1'b0;
    end else if (t_reg.cnt >= limit) begin
      t_next.done = 1'b1;
    end else if (tick) begin
      t_next.cnt = t_reg.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign expired = t_reg.done;
endmodule
`default_nettype wire

// [rtl/dss_sequencer.sv]
/*
  Drive safe stop sequencer: torque off, brake control, the three stop
  one variants, the direction violation reactions, the restart gate and
  an APB register file with interrupt status.
  Assumes all drive-side inputs are synchronous to sys_clk and that the
  speed monitors outside supply standstill and supervision verdicts.
*/
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dss_sequencer #(
  parameter int FSI_N = 3
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // function selection from the machine controller
  input  wire logic [FSI_N-1:0]  failsafe_input,
  input  wire logic              bus_sto_select,
  input  wire logic              bus_ss1_select,
  input  wire logic              sdi_select,
  input  wire logic              run_command,
  input  wire logic              quick_stop_command,
  // drive feedback
  input  wire logic              motor_on,
  input  wire logic              standstill,
  input  wire logic              speed_falling,
  input  wire logic              accel_ok,
  input  wire logic              sdi_deviation,
  // drive control
  output logic                   torque_enable,
  output logic                   quick_stop_ramp,
  output logic                   run_enable,
  output logic                   brake_close,
  output logic                   safe_brake_control,
  output logic                   sto_active,
  output logic [15:0]            status_word,
  // interrupt
  output logic                   irq
);
  import dss_pkg::*;

  typedef struct packed {
    dss_state_t                state;
    logic [DSS_CFG_W-1:0]      cfg;
    logic [31:0]               delay;
    logic [DSS_EV_W-1:0]       irq_st;
    logic [DSS_EV_W-1:0]       irq_en;
    logic [31:0]               rdata;
    logic                      err;
    logic                      armed;
    logic                      run_q;
    logic [15:0]               tick_cnt;
    logic                      tick;
    logic [15:0]               sword;
  } dss_regs_t;

  dss_regs_t r_reg;
  dss_regs_t r_next;

  // ---------------------------------------------------------------
  // selection decode
  // ---------------------------------------------------------------
  logic sto_sel;
  logic ss1_sel;
  logic tmr_run;
  logic tmr_expired;
  logic brake_cfg;
  logic sbc_en;
  logic sdi_ramp_rr;
  logic [1:0] stop_mode;

  // fail-safe input 0 selects torque off, input 1 selects stop one
  assign sto_sel     = failsafe_input[0] | bus_sto_select;
  assign ss1_sel     = failsafe_input[1] | bus_ss1_select;
  assign brake_cfg   = r_reg.cfg[DSS_CFG_BRAKE];
  assign sbc_en      = r_reg.cfg[DSS_CFG_SBC_EN];
  assign sdi_ramp_rr = r_reg.cfg[DSS_CFG_SDI_RR];
  assign stop_mode   = r_reg.cfg[DSS_CFG_MODE +: 2];

  // the delay runs during stop one and during the direction ramp stop
  assign tmr_run = (r_reg.state == DSS_ST_SS1) | (r_reg.state == DSS_ST_SDIR);

  dss_delay_timer #(
    .W (32)
  ) u_delay (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (tmr_run),
    .tick    (r_reg.tick),
    .limit   (r_reg.delay),
    .expired (tmr_expired)
  );

  // ---------------------------------------------------------------
  // apb decode helpers
  // ---------------------------------------------------------------
  function automatic logic dss_mapped(input logic [7:0] a);
    dss_mapped = (a == DSS_OFS_CONFIG) | (a == DSS_OFS_DELAY) |
                 (a == DSS_OFS_STATE)  | (a == DSS_OFS_FSI)   |
                 (a == DSS_OFS_IRQ_STAT) | (a == DSS_OFS_IRQ_CLR) |
                 (a == DSS_OFS_IRQ_EN);
  endfunction

  // read-only and write-only registers refuse the wrong direction
  function automatic logic dss_bad_dir(input logic [7:0] a, input logic wr);
    dss_bad_dir = (wr & ((a == DSS_OFS_STATE) | (a == DSS_OFS_FSI) |
                         (a == DSS_OFS_IRQ_STAT))) |
                  (!wr & (a == DSS_OFS_IRQ_CLR));
  endfunction

  logic setup;
  logic wr_do;
  logic [DSS_EV_W-1:0] ev;
  logic [DSS_EV_W-1:0] clr;

  assign setup = psel & !penable;
  assign wr_do = psel & penable & pwrite & !r_reg.err;

  // ---------------------------------------------------------------
  // next state of everything
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    ev     = '0;
    clr    = '0;

    // microsecond tick divider
    if (r_reg.tick_cnt == 16'(DSS_TICK_CYC - 1)) begin
      r_next.tick_cnt = '0;
      r_next.tick     = 1'b1;
    end else begin
      r_next.tick_cnt = r_reg.tick_cnt + 16'h0001;
      r_next.tick     = 1'b0;
    end

    // fail-safe input levels reported bit for bit
    r_next.sword = 16'(failsafe_input);

    // a restart needs a fresh rising run_command after the stop ends
    r_next.run_q = run_command;

    // sequencer
    case (r_reg.state)
      DSS_ST_RUN: begin
        if (sto_sel) begin
          r_next.state = DSS_ST_STO;
          ev[DSS_EV_STO] = 1'b1;
        end else if (ss1_sel) begin
          ev[DSS_EV_SS1] = 1'b1;
          // monitored variants go off at once with a stopped motor
          if (stop_mode != DSS_MODE_NONE && !motor_on) begin
            r_next.state = DSS_ST_STO;
            ev[DSS_EV_STO] = 1'b1;
          end else begin
            r_next.state = DSS_ST_SS1;
          end
        end else if (sdi_select && sdi_deviation) begin
          ev[DSS_EV_SDI] = 1'b1;
          if (sdi_ramp_rr) begin
            r_next.state = DSS_ST_SDIR;
          end else begin
            r_next.state = DSS_ST_COAST;
            ev[DSS_EV_COAST] = 1'b1;
          end
        end
      end
      DSS_ST_SS1: begin
        if (sto_sel) begin
          r_next.state = DSS_ST_STO;
          ev[DSS_EV_STO] = 1'b1;
        end else if (!ss1_sel) begin
          r_next.state = DSS_ST_RUN;
          r_next.armed = 1'b0;
        end else begin
          case (stop_mode)
            DSS_MODE_RAMP: begin
              if (!speed_falling && !standstill) begin
                r_next.state = DSS_ST_STO;
                ev[DSS_EV_MON] = 1'b1;
                ev[DSS_EV_STO] = 1'b1;
              end else if (standstill) begin
                r_next.state = DSS_ST_STO;
                ev[DSS_EV_STO] = 1'b1;
              end
            end
            DSS_MODE_ACCEL: begin
              if (!accel_ok) begin
                r_next.state = DSS_ST_STO;
                ev[DSS_EV_MON] = 1'b1;
                ev[DSS_EV_STO] = 1'b1;
              end else if (standstill) begin
                r_next.state = DSS_ST_STO;
                ev[DSS_EV_STO] = 1'b1;
              end
            end
            default: begin
              // the delay ends the stop unconditionally; with a brake
              // fitted an earlier standstill also ends it
              if (tmr_expired || (brake_cfg && standstill)) begin
                r_next.state = DSS_ST_STO;
                ev[DSS_EV_STO] = 1'b1;
              end
            end
          endcase
        end
      end
      DSS_ST_SDIR: begin
        if (sto_sel) begin
          r_next.state = DSS_ST_STO;
          ev[DSS_EV_STO] = 1'b1;
        end else if (standstill || tmr_expired) begin
          r_next.state = DSS_ST_COAST;
          ev[DSS_EV_COAST] = 1'b1;
        end
      end
      DSS_ST_COAST: begin
        // held until the direction monitor and both stop selections are deselected
        if (!sdi_select && !sto_sel && !ss1_sel) begin
          r_next.state = DSS_ST_RUN;
          r_next.armed = 1'b0;
        end
      end
      DSS_ST_STO: begin
        // both selections must be gone before leaving torque off
        if (!sto_sel && !ss1_sel) begin
          r_next.state = DSS_ST_RUN;
          r_next.armed = 1'b0;
        end
      end
      default: begin
        r_next.state = DSS_ST_STO;
      end
    endcase

    // arm the restart only on a rising run_command in the run state
    if (r_reg.state == DSS_ST_RUN && !sto_sel && !ss1_sel) begin
      if (!run_command) begin
        r_next.armed = 1'b0;
      end else if (!r_reg.run_q) begin
        r_next.armed = 1'b1;
      end
    end

    // register writes; taken in the access cycle
    if (wr_do) begin
      case (paddr)
        DSS_OFS_CONFIG:  r_next.cfg    = pwdata[DSS_CFG_W-1:0];
        DSS_OFS_DELAY:   r_next.delay  = pwdata;
        DSS_OFS_IRQ_CLR: clr           = pwdata[DSS_EV_W-1:0];
        DSS_OFS_IRQ_EN:  r_next.irq_en = pwdata[DSS_EV_W-1:0];
        default: begin
        end
      endcase
    end

    // a new event wins over a clear in the same cycle
    r_next.irq_st = (r_reg.irq_st & ~clr) | ev;

    // read data and error are prepared in the setup cycle so the
    // access cycle can answer at once from flip-flops
    if (setup) begin
      r_next.err   = !dss_mapped(paddr) | dss_bad_dir(paddr, pwrite);
      r_next.rdata = '0;
      if (!pwrite) begin
        case (paddr)
          DSS_OFS_CONFIG:   r_next.rdata = 32'(r_reg.cfg);
          DSS_OFS_DELAY:    r_next.rdata = r_reg.delay;
          DSS_OFS_STATE:    r_next.rdata = {22'h0, r_reg.armed, sto_active,
                                            3'h0, r_reg.state};
          DSS_OFS_FSI:      r_next.rdata = {16'h0, r_reg.sword};
          DSS_OFS_IRQ_STAT: r_next.rdata = 32'(r_reg.irq_st);
          DSS_OFS_IRQ_EN:   r_next.rdata = 32'(r_reg.irq_en);
          default:          r_next.rdata = '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // resets into torque off so nothing moves before the controller acts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg.state    <= DSS_ST_STO;
      r_reg.cfg      <= DSS_CFG_RST;
      r_reg.delay    <= DSS_DELAY_RST;
      r_reg.irq_st   <= '0;
      r_reg.irq_en   <= '0;
      r_reg.rdata    <= '0;
      r_reg.err      <= 1'b0;
      r_reg.armed    <= 1'b0;
      r_reg.run_q    <= 1'b0;
      r_reg.tick_cnt <= '0;
      r_reg.tick     <= 1'b0;
      r_reg.sword    <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // torque off covers both the selected state and the coast reaction
  assign sto_active = (r_reg.state == DSS_ST_STO) |
                      (r_reg.state == DSS_ST_COAST);
  assign torque_enable = !sto_active;

  // quick stop ramp during both braking states
  assign quick_stop_ramp = (r_reg.state == DSS_ST_SS1) |
                           (r_reg.state == DSS_ST_SDIR);

  // run permitted only when armed and nothing stopping is selected
  assign run_enable = (r_reg.state == DSS_ST_RUN) & r_reg.armed & !ss1_sel &
                      !sto_sel & run_command & quick_stop_command;

  // brake closes at once in torque off, and at standstill in stop one
  assign brake_close = brake_cfg & ((r_reg.state == DSS_ST_STO) |
                       ((r_reg.state == DSS_ST_SS1) & standstill));

  assign safe_brake_control = brake_cfg & sbc_en & sto_active;

  assign status_word = r_reg.sword;
  assign irq         = |(r_reg.irq_st & r_reg.irq_en);

  // zero wait states: the access cycle always completes
  assign pready  = 1'b1;
  assign prdata  = r_reg.rdata;
  assign pslverr = r_reg.err & psel & penable;
endmodule
`default_nettype wire

// [sim/dss_ctl_model.sv]
/*
  Machine controller model: turns the bench's wishes into selection and
  run levels, keeping the controller's ordering duties.
  Assumes wishes change right after a rising sys_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_ctl_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // wishes of the bench
  input  wire logic want_sto,
  input  wire logic want_ss1,
  input  wire logic want_run,
  // levels towards the block
  output logic      sel_sto,
  output logic      sel_ss1,
  output logic      run_cmd
);
  logic sto_q;
  logic ss1_q;
  // selections lag two edges and run one, so run always drops before a selection rises
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {sto_q, ss1_q, sel_sto, sel_ss1, run_cmd} <= 5'h14;
    end else begin
      sto_q   <= want_sto;
      ss1_q   <= want_ss1;
      sel_sto <= sto_q;
      sel_ss1 <= ss1_q;
      // run only once both selections are gone
      run_cmd <= want_run & ~want_sto & ~want_ss1 & ~sel_sto & ~sel_ss1;
    end
  end
endmodule
`default_nettype wire

// [sim/dss_seq_properties.sv]
/*
  Port checker of the safe stop sequencer.
  Assumes one clock domain and binding onto dss_sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_seq_properties #(
  parameter int FSI_N = 3
) (
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic [FSI_N-1:0] failsafe_input,
  input wire logic             bus_sto_select,
  input wire logic             bus_ss1_select,
  input wire logic             sdi_select,
  input wire logic             sdi_deviation,
  input wire logic             quick_stop_command,
  input wire logic             torque_enable,
  input wire logic             quick_stop_ramp,
  input wire logic             run_enable,
  input wire logic             safe_brake_control,
  input wire logic             sto_active,
  input wire logic [15:0]      status_word,
  input wire logic             irq
);
  logic sto_sel;
  logic ss1_sel;
  logic idle_run;
  // selections as the block sees them; idle_run marks plain running
  assign sto_sel  = failsafe_input[0] | bus_sto_select;
  assign ss1_sel  = failsafe_input[1] | bus_ss1_select;
  assign idle_run = torque_enable & ~quick_stop_ramp;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_sto_entry;
    sto_sel && idle_run |=> sto_active && !torque_enable;
  endproperty
  a_sto_entry: assert property (p_sto_entry) else $error("torque stays on");
  property p_sbc;
    safe_brake_control |-> sto_active && !torque_enable;
  endproperty
  a_sbc: assert property (p_sbc) else $error("brake control without torque off");
  property p_off_quiet;
    sto_active |-> !torque_enable && !run_enable;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("torque in off state");
  property p_status;
    $past(rst_n) |-> status_word == 16'($past(failsafe_input));
  endproperty
  a_status: assert property (p_status) else $error("status word wrong");
  property p_run_gate;
    run_enable |-> quick_stop_command && !sto_active && !quick_stop_ramp;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("run while stopping");
  property p_ramp_torque;
    quick_stop_ramp |-> torque_enable && !run_enable;
  endproperty
  a_ramp_torque: assert property (p_ramp_torque) else $error("ramp without torque");
  property p_ss1_entry;
    ss1_sel && !sto_sel && idle_run |=> quick_stop_ramp || sto_active;
  endproperty
  a_ss1_entry: assert property (p_ss1_entry) else $error("stop one ignored");
  property p_sdi_react;
    sdi_select && sdi_deviation && !sto_sel && !ss1_sel && idle_run
      |=> quick_stop_ramp || sto_active;
  endproperty
  a_sdi_react: assert property (p_sdi_react) else $error("direction fault ignored");
  // main scenarios reached
  c_sbc: cover property (sto_active && safe_brake_control);
  c_ramp_off: cover property (quick_stop_ramp ##1 sto_active);
  c_irq: cover property (irq);
endmodule
bind dss_sequencer dss_seq_properties #(.FSI_N(FSI_N)) u_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .failsafe_input(failsafe_input),
  .bus_sto_select(bus_sto_select), .bus_ss1_select(bus_ss1_select),
  .sdi_select(sdi_select), .sdi_deviation(sdi_deviation),
  .quick_stop_command(quick_stop_command), .torque_enable(torque_enable),
  .quick_stop_ramp(quick_stop_ramp), .run_enable(run_enable),
  .safe_brake_control(safe_brake_control), .sto_active(sto_active),
  .status_word(status_word), .irq(irq));
`default_nettype wire

// [sim/drive_safe_stop_sequencer_test.sv]
/*
  Self-checking bench of the safe stop sequencer.
  Assumes the controller model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module drive_safe_stop_sequencer_test;
  import dss_pkg::*;
  logic        sys_clk = 0;
  logic        rst_n = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, fsi2 = 0, bus_sto = 0, bus_ss1 = 0;
  logic        sdi_select = 0, sdi_deviation = 0, quick_stop_command = 1;
  logic        motor_on = 1, standstill = 0, speed_falling = 1, accel_ok = 1;
  logic        want_sto = 1, want_ss1 = 0, want_run = 0, sel_sto, sel_ss1, run_cmd;
  logic        torque_enable, quick_stop_ramp, run_enable, brake_close;
  logic        safe_brake_control, sto_active, irq;
  logic [15:0] status_word;
  int          n_fail = 0;
  int          n_tests = 0;
  // 250 MHz
  always #2 sys_clk = ~sys_clk;
  dss_ctl_model u_ctl (.sys_clk(sys_clk), .rst_n(rst_n), .want_sto(want_sto),
    .want_ss1(want_ss1), .want_run(want_run), .sel_sto(sel_sto),
    .sel_ss1(sel_ss1), .run_cmd(run_cmd));
  dss_sequencer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .failsafe_input({fsi2, sel_ss1, sel_sto}), .bus_sto_select(bus_sto),
    .bus_ss1_select(bus_ss1), .sdi_select(sdi_select), .run_command(run_cmd),
    .quick_stop_command(quick_stop_command), .motor_on(motor_on),
    .standstill(standstill), .speed_falling(speed_falling), .accel_ok(accel_ok),
    .sdi_deviation(sdi_deviation), .torque_enable(torque_enable),
    .quick_stop_ramp(quick_stop_ramp), .run_enable(run_enable),
    .brake_close(brake_close), .safe_brake_control(safe_brake_control),
    .sto_active(sto_active), .status_word(status_word), .irq(irq));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h", $time, m, got);
    end
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    @(posedge sys_clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      chk(0, 1, "apb hang");
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] x, logic ex);
    logic [31:0] q;
    logic        e;
    apb(0, a, 0, q, e);
    chk(q, x, "read data");
    chk(e, ex, "read error");
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1, a, d, q, e);
    chk(e, 0, "write error");
  endtask
  function automatic logic probe(int k);
    case (k)
      0: return run_enable;
      1: return sto_active;
      default: return quick_stop_ramp;
    endcase
  endfunction
  // bounded wait for an output, sampled mid-cycle, ends on a rising edge
  task automatic wait_on(int k, int lim);
    int i;
    for (i = 0; i < lim && probe(k) !== 1'b1; i++) @(negedge sys_clk);
    chk(probe(k), 1, "wait timed out");
    if (probe(k) !== 1'b1) tally_and_finish();
    @(posedge sys_clk);
  endtask
  // deselect all, let run_command rest low, then ask to run
  task automatic go_run();
    @(posedge sys_clk);
    {want_sto, want_ss1, bus_sto, bus_ss1, sdi_select, want_run} <= 6'h00;
    {standstill, sdi_deviation, motor_on} <= 3'b001;
    repeat (8) @(posedge sys_clk);
    want_run <= 1;
    wait_on(0, 50);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd_chk(DSS_OFS_CONFIG, 0, 0);
    rd_chk(DSS_OFS_DELAY, DSS_DELAY_RST, 0);
    rd_chk(8'h1C, 0, 1);
    rd_chk(DSS_OFS_IRQ_CLR, 0, 1);
    chk(sto_active, 1, "reset off state");
    wr(DSS_OFS_DELAY, 2);
    wr(DSS_OFS_IRQ_EN, 32'h1F);
    $display("test regs done");
  endtask
  task automatic t_sto();
    logic [31:0] q;
    logic        e;
    wr(DSS_OFS_CONFIG, 32'h3);
    go_run();
    want_sto <= 1;
    wait_on(1, 10);
    @(negedge sys_clk);
    chk({torque_enable, brake_close, safe_brake_control, irq}, 4'h7, "torque off");
    apb(0, DSS_OFS_IRQ_STAT, 0, q, e);
    chk(q[DSS_EV_STO], 1, "off event");
    wr(DSS_OFS_IRQ_CLR, 32'h1F);
    @(negedge sys_clk);
    chk(irq, 0, "irq cleared");
    $display("test sto done");
  endtask
  task automatic t_ss1_delay();
    int i;
    wr(DSS_OFS_CONFIG, 32'h0);
    go_run();
    want_ss1 <= 1;
    wait_on(2, 10);
    for (i = 0; i < 600 && sto_active !== 1'b1; i++) @(negedge sys_clk);
    chk(i >= 250 && i <= 510, 1, "stop delay length");
    chk({run_enable, brake_close}, 0, "restart refused");
    $display("test stop delay done");
  endtask
  task automatic t_ss1_mon();
    for (int m = 0; m < 3; m++) begin
      wr(DSS_OFS_CONFIG, (m << 2) | 3);
      if (m > 0) begin
        go_run();
        {want_ss1, speed_falling, accel_ok} <= 3'h4;
        wait_on(1, 10);
        go_run();
        {motor_on, speed_falling, accel_ok} <= 3'h3;
        want_ss1 <= 1;
        wait_on(1, 10);
      end
      go_run();
      if (m == 2) bus_ss1 <= 1;
      else want_ss1 <= 1;
      wait_on(2, 10);
      repeat (20) @(posedge sys_clk);
      chk(sto_active, 0, "ramp held");
      standstill <= 1;
      wait_on(1, 10);
      @(negedge sys_clk);
      chk({brake_close, safe_brake_control}, 2'h3, "brake at rest");
    end
    $display("test stop modes done");
  endtask
  task automatic t_sdi();
    logic [31:0] q;
    logic        e;
    wr(DSS_OFS_CONFIG, 32'h13);
    go_run();
    {sdi_select, sdi_deviation} <= 2'h3;
    wait_on(2, 10);
    standstill <= 1;
    wait_on(1, 10);
    @(negedge sys_clk);
    chk({brake_close, torque_enable}, 0, "coasting");
    apb(0, DSS_OFS_IRQ_STAT, 0, q, e);
    chk(q[DSS_EV_COAST] & q[DSS_EV_SDI], 1, "coast events");
    $display("test direction done");
  endtask
  task automatic t_fsi();
    for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk);
      fsi2 <= v[0];
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(status_word, {13'h0, v[0], sel_ss1, sel_sto}, "status word");
    end
    $display("test status done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1;
    t_regs();
    t_sto();
    t_ss1_delay();
    t_ss1_mon();
    t_sdi();
    t_fsi();
    tally_and_finish();
  end
endmodule
`default_nettype wire
